// ---- design/fsc_clipper.sv ----
// Purpose: Limits each audio sample magnitude to the clipping threshold
// Assumes: Signed samples, one per valid strobe, same clock
// Notes: Samples taken while normal operation is halted are output as zero
`timescale 1ns/1ps
module fsc_clipper #(
	parameter int SAMPLE_W = 24
) (
	input wire logic clk, // Control clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic ce, // Clock enable
	input wire logic signed [SAMPLE_W-1:0] sample_in, // Incoming sample
	input wire logic sample_in_valid, // Incoming sample strobe
	output logic signed [SAMPLE_W-1:0] sample_out, // Limited sample to modulator
	output logic sample_out_valid, // Limited sample strobe
	fsc_core_if.clip core // Threshold and halt
);

	typedef struct packed {
		logic signed [SAMPLE_W-1:0] sample;
		logic valid;
	} fsc_clip_state_t;

	fsc_clip_state_t st_reg;
	fsc_clip_state_t st_next;
	logic signed [SAMPLE_W:0] pos_lim;
	logic signed [SAMPLE_W:0] neg_lim;
	logic signed [SAMPLE_W:0] wide_in;

	// One extra bit keeps the negated limit from overflowing
	assign pos_lim = $signed({{(SAMPLE_W + 1 - fsc_pkg::CLIP_LEVEL_W){1'b0}}, core.clip_level});
	assign neg_lim = -pos_lim;
	assign wide_in = {sample_in[SAMPLE_W-1], sample_in};

	// Clamp to plus or minus the threshold
	always_comb
	begin
		st_next = st_reg;
		st_next.valid = sample_in_valid;
		if (sample_in_valid)
		begin
			if (core.halt)
				st_next.sample = '0;
			else if (wide_in > pos_lim)
				st_next.sample = pos_lim[SAMPLE_W-1:0];
			else if (wide_in < neg_lim)
				st_next.sample = neg_lim[SAMPLE_W-1:0];
			else
				st_next.sample = sample_in;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			st_reg <= '0;
		else if (ce)
			st_reg <= st_next;
	end

	assign sample_out = st_reg.sample;
	assign sample_out_valid = st_reg.valid;

endmodule // fsc_clipper

// ---- design/fsc_core_if.sv ----
// Purpose: Carrier between the register bank, fault tracker and clipper
// Assumes: All signals in the CLK domain
// Notes: No clocking block; plain modports
`timescale 1ns/1ps
interface fsc_core_if;
	logic [1:0] oc_sel; // Overcurrent threshold selection
	logic [19:0] clip_level; // Assembled clipping threshold
	logic [3:0] flags; // Clock, overcurrent, dc, overtemp flags
	logic halt; // Normal operation stopped

	modport regs (output oc_sel, output clip_level, input flags, input halt);
	modport fault (input oc_sel, output flags, output halt);
	modport clip (input clip_level, input halt);
endinterface // fsc_core_if

// ---- design/fsc_fault.sv ----
// Purpose: Fault detection and latching with shutdown-toggle recovery
// Assumes: Clock, dc and overtemp indications arrive as asynchronous levels from analog monitors
// Notes: Latched flags clear while shutdown is active; a new event wins over the clear
`timescale 1ns/1ps
module fsc_fault #(
	parameter int CUR_W = 12,
	parameter logic [11:0] OC_NOMINAL = 12'h800
) (
	input wire logic clk, // Control clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic ce, // Clock enable, freezes state when low
	input wire logic clock_fault_async, // Clock monitor level, asynchronous
	input wire logic dc_fault_async, // DC offset monitor level, asynchronous
	input wire logic overtemp_async, // Die temperature monitor level, asynchronous
	input wire logic shutdown_pin_n_async, // Speaker shutdown pin, active low, asynchronous
	input wire logic shutdown_bit_n, // Speaker shutdown control bit, active low
	input wire logic [CUR_W-1:0] current_mag, // Output current magnitude, same clock
	fsc_core_if.fault core // Link to register bank and clipper
);

	typedef struct packed {
		logic [1:0] clk_sync;
		logic [1:0] dc_sync;
		logic [1:0] ot_sync;
		logic [1:0] sd_sync;
		logic clock_error_flag;
		logic overcurrent_error_flag;
		logic dce;
		logic overtemp_error_flag;
		logic halt;
	} fsc_fault_state_t;

	fsc_fault_state_t st_reg;
	fsc_fault_state_t st_next;
	logic shutdown_active;
	logic oc_trip;

	// Scale the nominal trip level by the selected fraction
	function automatic logic [CUR_W-1:0] oc_level(input logic [1:0] sel);
		logic [CUR_W+1:0] nom;
		logic [CUR_W+1:0] prod;
		nom = {2'h0, OC_NOMINAL[CUR_W-1:0]};
		prod = nom;
		case (sel)
			fsc_pkg::FSC_OC_FULL: prod = nom;
			fsc_pkg::FSC_OC_75: prod = (nom + (nom << 1)) >> 2;
			fsc_pkg::FSC_OC_50: prod = nom >> 1;
			fsc_pkg::FSC_OC_25: prod = nom >> 2;
			default: prod = nom;
		endcase
		return prod[CUR_W-1:0];
	endfunction

	// Either the pin or the control bit holds the speaker in shutdown
	assign shutdown_active = ~st_reg.sd_sync[1] | ~shutdown_bit_n;
	assign oc_trip = current_mag > oc_level(core.oc_sel);

	// Next state: sync pins, latch faults, clear on shutdown with set winning
	always_comb
	begin
		st_next = st_reg;
		st_next.clk_sync = {st_reg.clk_sync[0], clock_fault_async};
		st_next.dc_sync = {st_reg.dc_sync[0], dc_fault_async};
		st_next.ot_sync = {st_reg.ot_sync[0], overtemp_async};
		st_next.sd_sync = {st_reg.sd_sync[0], shutdown_pin_n_async};
		st_next.clock_error_flag = st_reg.clk_sync[1];
		st_next.overcurrent_error_flag = (st_reg.overcurrent_error_flag & ~shutdown_active) | oc_trip;
		st_next.dce = (st_reg.dce & ~shutdown_active) | st_reg.dc_sync[1];
		st_next.overtemp_error_flag = (st_reg.overtemp_error_flag & ~shutdown_active) | st_reg.ot_sync[1];
		// Clock error only halts while present, so operation resumes by itself
		st_next.halt = shutdown_active | st_next.clock_error_flag | st_next.overcurrent_error_flag | st_next.dce
			| st_next.overtemp_error_flag;
	end

	// State register; shutdown sync resets to released so no false clear
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st_reg <= '0;
			st_reg.sd_sync <= 2'h3;
			st_reg.halt <= 1'b1;
		end
		else if (ce)
		begin
			st_reg <= st_next;
		end
	end

	assign core.flags = {st_reg.clock_error_flag, st_reg.overcurrent_error_flag, st_reg.dce, st_reg.overtemp_error_flag};
	assign core.halt = st_reg.halt;

endmodule // fsc_fault

// ---- design/fsc_pkg.sv ----
// Purpose: Shared constants for the fault status and clip threshold register block
// Assumes: Eight-bit control port registers, one CLK domain
// Notes: All offsets, named field positions and register field reset values live here
package fsc_pkg;

	// Register offsets on the control port
	localparam logic [7:0] ADDR_FAULT = 8'h08;
	localparam logic [7:0] ADDR_CLIP_MID = 8'h10;
	localparam logic [7:0] ADDR_CLIP_LOW = 8'h11;
	localparam logic [7:0] ADDR_RSVD_FIRST = 8'h09;
	localparam logic [7:0] ADDR_RSVD_LAST = 8'h0F;

	// Fault register field positions
	localparam int FLT_OTE_BIT = 0;
	localparam int FLT_DCE_BIT = 1;
	localparam int FLT_OCE_BIT = 2;
	localparam int FLT_CLOCK_ERROR_FLAG_BIT = 3;
	localparam int FLT_THR_LSB = 4;
	localparam int FLT_THR_MSB = 5;

	// Lower clip register field positions
	localparam int CLIP_LOW_FIELD_LSB = 2;
	localparam int CLIP_LOW_FIELD_MSB = 7;

	// Assembled clipping threshold layout
	localparam int CLIP_LEVEL_W = 20;
	localparam int CLIP_HI_W = 6;
	localparam int CLIP_MID_W = 8;
	localparam int CLIP_LO_W = 6;

	// Reset values
	localparam logic [1:0] OC_SEL_RESET = 2'h0;
	localparam logic [7:0] CLIP_MID_RESET = 8'h01;
	localparam logic [5:0] CLIP_LOW_FIELD_RESET = 6'h01;
	localparam logic [1:0] CLIP_LOW_RSVD_RESET = 2'h0;
	localparam logic [7:0] RDATA_RESET = 8'h00;

	// Overcurrent scaling selections
	typedef enum logic [1:0] {
		FSC_OC_FULL = 2'h0,
		FSC_OC_75 = 2'h1,
		FSC_OC_50 = 2'h2,
		FSC_OC_25 = 2'h3
	} fsc_oc_sel_t;

endpackage

// ---- design/fsc_regs.sv ----
// Purpose: Fault configuration, error status and lower clip threshold registers
// Assumes: Control port decoded upstream into address, strobes and data bytes
// Notes: Read data is registered and appears the cycle after a read strobe
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module fsc_regs #(
	parameter int SAMPLE_W = 24,
	parameter int CUR_W = 12,
	parameter logic [11:0] OC_NOMINAL = 12'h800
) (
	input wire logic CLK, // Control clock, 40 MHz
	input wire logic RST, // Synchronous reset, active high
	input wire logic CE, // Clock enable, freezes all state when low
	input wire logic [7:0] REG_ADDR, // Register offset
	input wire logic [7:0] REG_WDATA, // Write data byte
	input wire logic REG_WR, // Write strobe, one cycle
	input wire logic REG_RD, // Read strobe, one cycle
	output logic [7:0] REG_RDATA, // Registered read data
	output logic REG_RVALID, // Read data valid, one cycle
	input wire logic [5:0] CLIP_HI_BITS, // Threshold bits 19:14 from their own register
	input wire logic CLOCK_FAULT, // Clock monitor level, asynchronous
	input wire logic DC_FAULT, // DC offset monitor level, asynchronous
	input wire logic OVERTEMP, // Die temperature monitor level, asynchronous
	input wire logic SPK_SHUTDOWN_N, // Speaker shutdown pin, active low
	input wire logic SHUTDOWN_BIT_N, // Speaker shutdown control bit, active low
	input wire logic [CUR_W-1:0] CURRENT_MAG, // Output current magnitude
	input wire logic signed [SAMPLE_W-1:0] AUDIO_IN, // Audio sample in
	input wire logic AUDIO_IN_VALID, // Audio sample strobe in
	output logic signed [SAMPLE_W-1:0] AUDIO_OUT, // Limited sample to modulator
	output logic AUDIO_OUT_VALID, // Limited sample strobe
	output logic [3:0] ERROR_FLAGS, // Clock, overcurrent, dc, overtemp
	output logic RUN_OK // Normal operation allowed
);

	typedef struct packed {
		logic [1:0] oc_sel;
		logic [7:0] clip_mid;
		logic [5:0] clip_low;
		logic [1:0] clip_rsvd;
		logic [7:0] rdata;
		logic rvalid;
		logic [3:0] flags_out;
		logic run_ok;
	} fsc_regs_state_t;

	fsc_regs_state_t st_reg;
	fsc_regs_state_t st_next;
	fsc_core_if core_bus ();

	////////////////////////////////////////////////////////////////////////////
	// Read data decode, shared by the read path

	function automatic logic [7:0] read_mux(
		input logic [7:0] addr,
		input fsc_regs_state_t s,
		input logic [3:0] flags
	);
		logic [7:0] v;
		v = 8'h00;
		case (addr)
			fsc_pkg::ADDR_FAULT:
			begin
				// Top two bits stay zero, no storage behind them
				v = {2'h0, s.oc_sel, flags};
			end
			fsc_pkg::ADDR_CLIP_MID: v = s.clip_mid;
			fsc_pkg::ADDR_CLIP_LOW: v = {s.clip_low, s.clip_rsvd};
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Register writes and reads

	// Only the selector field of the fault register accepts data
	always_comb
	begin
		st_next = st_reg;
		st_next.rvalid = REG_RD;
		if (REG_WR)
		begin
			case (REG_ADDR)
				fsc_pkg::ADDR_FAULT:
				begin
					// Flag and reserved bits are dropped on write
					st_next.oc_sel =
						REG_WDATA[fsc_pkg::FLT_THR_MSB:fsc_pkg::FLT_THR_LSB];
				end
				fsc_pkg::ADDR_CLIP_MID: st_next.clip_mid = REG_WDATA;
				fsc_pkg::ADDR_CLIP_LOW:
				begin
					st_next.clip_low = REG_WDATA[fsc_pkg::CLIP_LOW_FIELD_MSB:
						fsc_pkg::CLIP_LOW_FIELD_LSB];
					// Reserved pair is storage only, steering nothing
					st_next.clip_rsvd = REG_WDATA[1:0];
				end
				// Reserved window 0x09 to 0x0F and anything else is ignored
				default: st_next = st_next;
			endcase
		end
		if (REG_RD)
			st_next.rdata = read_mux(REG_ADDR, st_reg, core_bus.flags);
		st_next.flags_out = core_bus.flags;
		st_next.run_ok = ~core_bus.halt;
	end

	// State register with documented reset values
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			st_reg.oc_sel <= fsc_pkg::OC_SEL_RESET;
			st_reg.clip_mid <= fsc_pkg::CLIP_MID_RESET;
			st_reg.clip_low <= fsc_pkg::CLIP_LOW_FIELD_RESET;
			st_reg.clip_rsvd <= fsc_pkg::CLIP_LOW_RSVD_RESET;
			st_reg.rdata <= fsc_pkg::RDATA_RESET;
			st_reg.rvalid <= 1'b0;
			st_reg.flags_out <= 4'h0;
			st_reg.run_ok <= 1'b0;
		end
		else if (CE)
		begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Threshold assembly and submodules

	// High bits come from the neighbouring register outside this bank
	assign core_bus.oc_sel = st_reg.oc_sel;
	assign core_bus.clip_level = {CLIP_HI_BITS, st_reg.clip_mid, st_reg.clip_low};

	fsc_fault #(
		.CUR_W(CUR_W),
		.OC_NOMINAL(OC_NOMINAL)
	) u_fault (
		.clk(CLK),
		.rst(RST),
		.ce(CE),
		.clock_fault_async(CLOCK_FAULT),
		.dc_fault_async(DC_FAULT),
		.overtemp_async(OVERTEMP),
		.shutdown_pin_n_async(SPK_SHUTDOWN_N),
		.shutdown_bit_n(SHUTDOWN_BIT_N),
		.current_mag(CURRENT_MAG),
		.core(core_bus.fault)
	);

	fsc_clipper #(
		.SAMPLE_W(SAMPLE_W)
	) u_clip (
		.clk(CLK),
		.rst(RST),
		.ce(CE),
		.sample_in(AUDIO_IN),
		.sample_in_valid(AUDIO_IN_VALID),
		.sample_out(AUDIO_OUT),
		.sample_out_valid(AUDIO_OUT_VALID),
		.core(core_bus.clip)
	);

	// Outputs straight from flip-flops
	assign REG_RDATA = st_reg.rdata;
	assign REG_RVALID = st_reg.rvalid;
	assign ERROR_FLAGS = st_reg.flags_out;
	assign RUN_OK = st_reg.run_ok;

endmodule // fsc_regs

// ---- sim/fsc_host.sv ----
// Purpose: Host model for the control port and shutdown controls
// Assumes: Drives 1 ns after the rising edge
// Notes: Released lines show the inverse of the last value
`timescale 1ns/1ps
module fsc_host (
	input wire logic CLK, // Clock
	input wire logic [7:0] REG_RDATA, // Read data
	input wire logic REG_RVALID, // Read valid
	output logic [7:0] REG_ADDR, // Offset
	output logic [7:0] REG_WDATA, // Write byte
	output logic REG_WR, // Write strobe
	output logic REG_RD, // Read strobe
	output logic SPK_SHUTDOWN_N, // Pin
	output logic SHUTDOWN_BIT_N // Bit
);
	////////////////////////////////////////////////
	// Idle levels from time zero
	initial
	begin
		REG_ADDR = 8'h00;
		REG_WDATA = 8'h00;
		{REG_WR, REG_RD} = 2'b00;
		{SPK_SHUTDOWN_N, SHUTDOWN_BIT_N} = 2'b11;
	end
	// One-cycle write strobe, then stale values are scrambled
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge CLK);
		#1;
		{REG_ADDR, REG_WDATA, REG_WR} = {a, d, 1'b1};
		@(posedge CLK);
		#1;
		{REG_ADDR, REG_WDATA, REG_WR} = {~a, ~d, 1'b0};
	endtask
	// Answer is registered, so it is taken one edge after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		@(posedge CLK);
		#1;
		{REG_ADDR, REG_RD} = {a, 1'b1};
		@(posedge CLK);
		#1;
		{REG_ADDR, REG_RD} = {~a, 1'b0};
		{d, ok} = {REG_RDATA, REG_RVALID};
	endtask
	// Shutdown held long enough to pass the pin synchroniser
	task automatic shut(input logic use_pin);
		@(posedge CLK);
		#1;
		{SPK_SHUTDOWN_N, SHUTDOWN_BIT_N} = use_pin ? 2'b01 : 2'b10;
		repeat (4) @(posedge CLK);
		#1;
		{SPK_SHUTDOWN_N, SHUTDOWN_BIT_N} = 2'b11;
	endtask
endmodule // fsc_host

// ---- sim/fsc_regs_properties.sv ----
// Purpose: Port checks for the fault status and clip register block
// Assumes: One CLK domain, synchronous active-high RST
// Notes: Bounds follow the hand-over latencies
`timescale 1ns/1ps
module fsc_regs_properties #(
	parameter int SAMPLE_W = 24
) (
	input wire logic CLK, // Clock
	input wire logic RST, // Reset
	input wire logic CE, // Enable
	input wire logic [7:0] REG_ADDR, // Offset
	input wire logic REG_RD, // Read strobe
	input wire logic [7:0] REG_RDATA, // Read data
	input wire logic REG_RVALID, // Read valid
	input wire logic [5:0] CLIP_HI_BITS, // Top bits
	input wire logic CLOCK_FAULT, // Clock monitor
	input wire logic SPK_SHUTDOWN_N, // Pin
	input wire logic SHUTDOWN_BIT_N, // Bit
	input wire logic signed [SAMPLE_W-1:0] AUDIO_IN, // In
	input wire logic AUDIO_IN_VALID, // In strobe
	input wire logic signed [SAMPLE_W-1:0] AUDIO_OUT, // Out
	input wire logic AUDIO_OUT_VALID, // Out strobe
	input wire logic [3:0] ERROR_FLAGS, // Flags
	input wire logic RUN_OK // Running
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);
	logic [2:0] calm_reg;
	////////////////////////////////////////////////
	// Cycles since shutdown; saturates so the pin synchroniser delay is covered
	always_ff @(posedge CLK)
	begin
		if (RST || !SPK_SHUTDOWN_N || !SHUTDOWN_BIT_N)
			calm_reg <= 3'h0;
		else if (calm_reg != 3'h7)
			calm_reg <= calm_reg + 3'h1;
	end
	// Clock monitor held bad or good for a full sync plus latch time
	sequence s_clk_bad;
		(CE && CLOCK_FAULT) [*6];
	endsequence
	sequence s_clk_good;
		(CE && !CLOCK_FAULT) [*6];
	endsequence
	AST_RD_ANSWER: assert property (CE |=> REG_RVALID == $past(REG_RD))
		else $error("Read valid does not follow read strobe");
	AST_FAULT_RSVD: assert property (CE && REG_RD && REG_ADDR == 8'h08 |=> REG_RDATA[7:6] == 2'h0)
		else $error("Fault register top bits not zero");
	AST_FLAG_READ: assert property (CE && REG_RD && REG_ADDR == 8'h08 |=> REG_RDATA[3:0] == ERROR_FLAGS)
		else $error("Fault register flags differ from flag outputs");
	AST_CLOCK_ERROR_FLAG_SET: assert property (s_clk_bad |-> ERROR_FLAGS[3])
		else $error("Clock error flag missing");
	AST_CLOCK_ERROR_FLAG_CLEAR: assert property (s_clk_good |-> !ERROR_FLAGS[3])
		else $error("Clock error flag stuck");
	AST_FAULT_HOLD: assert property (calm_reg == 3'h7 |=> (ERROR_FLAGS[2:0] & $past(ERROR_FLAGS[2:0])) == $past(ERROR_FLAGS[2:0]))
		else $error("Latched flag dropped without shutdown");
	AST_HALT_RUN: assert property (|ERROR_FLAGS[2:0] |-> !RUN_OK)
		else $error("Running with a latched fault");
	AST_AUDIO_VALID: assert property (CE |=> AUDIO_OUT_VALID == $past(AUDIO_IN_VALID))
		else $error("Sample strobe not passed on");
	AST_HALT_MUTE: assert property (AUDIO_OUT_VALID && !RUN_OK |-> AUDIO_OUT == '0)
		else $error("Sample passed while halted");
	AST_CLIP_PASS: assert property (CE && AUDIO_IN_VALID && !AUDIO_IN[SAMPLE_W-1] && AUDIO_IN <= {CLIP_HI_BITS, 14'h0} |=> !RUN_OK || AUDIO_OUT == $past(AUDIO_IN))
		else $error("Small sample altered");
endmodule // fsc_regs_properties
bind fsc_regs fsc_regs_properties #(.SAMPLE_W(SAMPLE_W)) u_fsc_regs_properties (.CLK(CLK),
	.RST(RST), .CE(CE), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
	.REG_RVALID(REG_RVALID), .CLIP_HI_BITS(CLIP_HI_BITS), .CLOCK_FAULT(CLOCK_FAULT),
	.SPK_SHUTDOWN_N(SPK_SHUTDOWN_N), .SHUTDOWN_BIT_N(SHUTDOWN_BIT_N), .AUDIO_IN(AUDIO_IN),
	.AUDIO_IN_VALID(AUDIO_IN_VALID), .AUDIO_OUT(AUDIO_OUT), .AUDIO_OUT_VALID(AUDIO_OUT_VALID),
	.ERROR_FLAGS(ERROR_FLAGS), .RUN_OK(RUN_OK));

// ---- sim/testbench.sv ----
// Purpose: Self-checking bench for the fault status and clip registers
// Assumes: Host model drives the register port and shutdown
// Notes: Inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module testbench;
	localparam logic [11:0] OC_NOM = 12'h800;
	logic CLK, RST, CE, REG_WR, REG_RD, REG_RVALID, CLOCK_FAULT, DC_FAULT, OVERTEMP;
	logic SPK_SHUTDOWN_N, SHUTDOWN_BIT_N, AUDIO_IN_VALID, AUDIO_OUT_VALID, RUN_OK;
	logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
	logic [5:0] CLIP_HI_BITS;
	logic [11:0] CURRENT_MAG;
	logic signed [23:0] AUDIO_IN, AUDIO_OUT;
	logic [3:0] ERROR_FLAGS;
	int err_count = 0;
	int checks_done = 0;
	fsc_host u_fsc_host (.CLK(CLK), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
		.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
		.SPK_SHUTDOWN_N(SPK_SHUTDOWN_N), .SHUTDOWN_BIT_N(SHUTDOWN_BIT_N));
	fsc_regs #(.SAMPLE_W(24), .CUR_W(12), .OC_NOMINAL(OC_NOM)) u_fsc_regs (.CLK(CLK),
		.RST(RST), .CE(CE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
		.REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
		.CLIP_HI_BITS(CLIP_HI_BITS), .CLOCK_FAULT(CLOCK_FAULT), .DC_FAULT(DC_FAULT),
		.OVERTEMP(OVERTEMP), .SPK_SHUTDOWN_N(SPK_SHUTDOWN_N), .SHUTDOWN_BIT_N(SHUTDOWN_BIT_N),
		.CURRENT_MAG(CURRENT_MAG), .AUDIO_IN(AUDIO_IN), .AUDIO_IN_VALID(AUDIO_IN_VALID),
		.AUDIO_OUT(AUDIO_OUT), .AUDIO_OUT_VALID(AUDIO_OUT_VALID), .ERROR_FLAGS(ERROR_FLAGS),
		.RUN_OK(RUN_OK));
	////////////////////////////////////////////////
	// Shared helpers
	task automatic report_and_stop();
		if (err_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask
	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
		checks_done++;
		if (s !== e)
		begin
			$display("MISMATCH %s expected %h seen %h", n, e, s);
			err_count++;
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic ok;
		u_fsc_host.rd(a, d, ok);
		chk("rvalid", 24'h1, {23'h0, ok});
		chk("rdata", {16'h0, e}, {16'h0, d});
	endtask
	// Bit 4 stands for RUN_OK, lower indices for the flags
	function automatic logic st(input int i);
		st = (i == 4) ? RUN_OK : ERROR_FLAGS[i];
	endfunction
	task automatic wt(input int i, input logic v);
		int n;
		n = 0;
		while (st(i) !== v && n < 30)
		begin
			tick(1);
			n++;
		end
		checks_done++;
		if (st(i) !== v)
		begin
			$display("MISMATCH status %0d expected %b seen %b", i, v, st(i));
			err_count++;
			report_and_stop();
		end
	endtask
	task automatic send(input logic signed [23:0] s, input logic signed [23:0] e);
		{AUDIO_IN, AUDIO_IN_VALID} = {s, 1'b1};
		tick(1);
		chk("audio", e, AUDIO_OUT);
		// Strobe low for one edge so back-to-back sends never reassign it at once
		AUDIO_IN_VALID = 1'b0;
		tick(1);
	endtask
	////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		rchk(8'h08, 8'h00);
		rchk(8'h10, 8'h01);
		rchk(8'h11, 8'h04);
	endtask
	task automatic t_regs();
		u_fsc_host.wr(8'h10, 8'hAB);
		rchk(8'h10, 8'hAB);
		u_fsc_host.wr(8'h11, 8'hFC);
		rchk(8'h11, 8'hFC);
		u_fsc_host.wr(8'h08, 8'hFF);
		rchk(8'h08, 8'h30);
		// Unmapped offset outside the reserved window, which the host never touches
		u_fsc_host.wr(8'h20, 8'h55);
		rchk(8'h20, 8'h00);
		CE = 1'b0;
		u_fsc_host.wr(8'h10, 8'h5A);
		CE = 1'b1;
		rchk(8'h10, 8'hAB);
		u_fsc_host.wr(8'h08, 8'h00);
	endtask
	task automatic t_clk();
		CLOCK_FAULT = 1'b1;
		wt(3, 1'b1);
		rchk(8'h08, 8'h08);
		CLOCK_FAULT = 1'b0;
		wt(3, 1'b0);
		wt(4, 1'b1);
	endtask
	// Trip level is strictly above the scaled nominal for every selection
	task automatic t_oc();
		logic [11:0] lvl;
		for (int s = 0; s < 4; s++)
		begin
			lvl = 12'((int'(OC_NOM) * (4 - s)) / 4);
			u_fsc_host.wr(8'h08, {2'h0, 2'(s), 4'h0});
			CURRENT_MAG = lvl;
			tick(8);
			chk("oc quiet", 24'h0, {23'h0, ERROR_FLAGS[2]});
			CURRENT_MAG = lvl + 12'h1;
			wt(2, 1'b1);
			CURRENT_MAG = 12'h0;
			tick(10);
			chk("oc held", 24'h1, {23'h0, ERROR_FLAGS[2]});
			chk("oc halt", 24'h0, {23'h0, RUN_OK});
			u_fsc_host.shut(1'(s));
			wt(2, 1'b0);
			wt(4, 1'b1);
		end
	endtask
	task automatic t_latch();
		for (int k = 0; k < 2; k++)
		begin
			{DC_FAULT, OVERTEMP} = (k == 0) ? 2'b10 : 2'b01;
			wt(1 - k, 1'b1);
			{DC_FAULT, OVERTEMP} = 2'b00;
			tick(12);
			chk("latched", 24'h1, {23'h0, ERROR_FLAGS[1 - k]});
			send(24'h001000, 24'h0);
			u_fsc_host.shut(1'(k));
			wt(1 - k, 1'b0);
			wt(4, 1'b1);
		end
	endtask
	task automatic t_clip();
		logic signed [23:0] thr;
		thr = {4'h0, 6'h01, 8'h12, 6'h05};
		CLIP_HI_BITS = 6'h01;
		u_fsc_host.wr(8'h10, 8'h12);
		u_fsc_host.wr(8'h11, {6'h05, 2'h0});
		tick(2);
		send(24'h7FFFFF, thr);
		send(24'sh800000, -thr);
		send(24'h001000, 24'h001000);
		send(thr, thr);
		send(thr + 24'sh1, thr);
	endtask
	////////////////////////////////////////////////
	// Clock at 40 MHz
	initial
	begin
		CLK = 1'b0;
		forever #12.5 CLK = ~CLK;
	end
	// Reset for 20 cycles, then every scenario in turn
	initial
	begin
		{RST, CE, CLOCK_FAULT, DC_FAULT, OVERTEMP, AUDIO_IN_VALID} = 6'h30;
		{CLIP_HI_BITS, CURRENT_MAG, AUDIO_IN} = '0;
		tick(20);
		RST = 1'b0;
		t_reset();
		t_regs();
		t_clk();
		t_oc();
		t_latch();
		t_clip();
		report_and_stop();
	end
endmodule // testbench
